// ---- hw/edge_trigger_detect.sv ----
// synchroniser and per-bit trigger detector
// assumes level_in is asynchronous; mode_in comes from the system clock domain
`timescale 1ns/1ps
`default_nettype none
module edge_trigger_detect #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    // raw levels and per-bit trigger selection
    input wire logic [W-1:0] level_in,
    input wire logic [2*W-1:0] mode_in,
    // detected events
    event_if.src ev
);
    logic [W-1:0] meta_reg; // first stage, read only by sync_reg
    logic [W-1:0] sync_reg; // settled level
    logic [W-1:0] prev_reg; // level one cycle earlier

    // two-flop synchroniser plus history stage
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
        end
        else
        begin
            meta_reg <= level_in;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // per-bit trigger decode; level mode fires every cycle the input is high
    for (genvar i = 0; i < W; i++)
    begin : g_bit
        pmic_irq_pkg::trig_mode_e mode;
        assign mode = pmic_irq_pkg::trig_mode_e'(mode_in[2*i+1:2*i]);
        always_comb
        begin
            case (mode)
                pmic_irq_pkg::trig_rise: ev.pulse[i] = sync_reg[i] & ~prev_reg[i];
                pmic_irq_pkg::trig_fall: ev.pulse[i] = ~sync_reg[i] & prev_reg[i];
                pmic_irq_pkg::trig_both: ev.pulse[i] = sync_reg[i] ^ prev_reg[i];
                pmic_irq_pkg::trig_level: ev.pulse[i] = sync_reg[i];
                default: ev.pulse[i] = 1'b0;
            endcase
        end
    end

endmodule : edge_trigger_detect
`default_nettype wire

// ---- hw/event_if.sv ----
// event pulse carrier between the trigger detector and the status logic
// assumes both ends run on the same system clock
`timescale 1ns/1ps
`default_nettype none
interface event_if #(parameter int W = 1);
    logic [W-1:0] pulse; // event per source, one cycle wide except in level mode
    modport src (output pulse);
    modport snk (input pulse);
endinterface : event_if
`default_nettype wire

// ---- hw/pmic_irq_pkg.sv ----
// constants for the regulator fault and pin interrupt status block
// assumes one system clock; APB byte address is four times a register index
package pmic_irq_pkg;

    // bus widths
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;
    localparam int IDX_W = 16;

    // register indices; byte address is index times four
    localparam logic [15:0] IDX_LDO_UV = 16'h4013;
    localparam logic [15:0] IDX_CONV_FAULT = 16'h4014;
    localparam logic [15:0] IDX_PIN_STATUS = 16'h4015;
    localparam logic [15:0] IDX_GROUP_MASK = 16'h4018;
    localparam logic [15:0] IDX_PIN_MODE = 16'h4040;
    localparam logic [15:0] IDX_GROUP_PEND = 16'h4041;

    // source counts
    localparam int N_LDO = 10;
    localparam int N_CONV = 4;
    localparam int N_OC = 2;
    localparam int N_PIN = 12;
    localparam int N_FAULT = 16;

    // positions of fault sources inside the fault event vector
    localparam int EV_LDO_LSB = 0;
    localparam int EV_CONV_LSB = 10;
    localparam int EV_OC_LSB = 14;

    // field positions in the converter fault register
    localparam int CONV_UV_LSB = 0;
    localparam int CONV_OC_LSB = 8;

    // group mask bits and their reset value (all masked)
    localparam int MASK_UV_BIT = 0;
    localparam int MASK_HC_BIT = 1;
    localparam int MASK_GP_BIT = 13;
    localparam logic [31:0] MASK_RESET = 32'h0000_2003;

    // group pending bits
    localparam int PEND_UV_BIT = 0;
    localparam int PEND_HC_BIT = 1;
    localparam int PEND_GP_BIT = 2;

    // pin trigger selection, two bits per pin
    typedef enum logic [1:0] {trig_rise, trig_fall, trig_both, trig_level} trig_mode_e;
    localparam int MODE_W = 2;
    localparam logic [23:0] PIN_MODE_RESET = 24'h00_0000;

endpackage : pmic_irq_pkg

// ---- hw/pmic_irq_status.sv ----
// sticky fault and pin interrupt status with group masks behind an APB slave
// assumes raw fault and pin levels are asynchronous to clk_sys_in
// assumes the APB master holds each request until pready is seen high
`timescale 1ns/1ps
`default_nettype none
// Contract
// - ten regulator undervoltage flags, rising edge
// - four converter undervoltage flags, bits 0-3
// - converter 2 overcurrent flag at bit 9
// - converter 1 overcurrent flag at bit 8
// - pin 4-12 flags in bits 3-11
// - pin flag trigger follows its mode setting
// - flags stick until a one written clears
// - pin 1-3 flags in bits 0-2
// - group masks reset masked, gate interrupt
module pmic_irq_status (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [17:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // raw fault conditions
    input wire logic [9:0] ldo_undervolt_in,
    input wire logic [3:0] conv_undervolt_in,
    input wire logic [1:0] buck_overcurrent_in,
    // general-purpose pin levels
    input wire logic [11:0] pin_level_in,
    // system interrupt, high while an unmasked group is pending
    output logic irq_out
);

    // shared helpers, each used by more than one process
    // byte-lane expansion of the strobes, used by every writable register
    function automatic logic [31:0] lane_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = '0;
        for (int b = 0; b < 4; b++)
        begin
            m[8*b +: 8] = {8{strb[b]}};
        end
        return m;
    endfunction : lane_mask

    // aligned hit on a register index
    function automatic logic reg_hit(input logic [17:0] addr, input logic [15:0] idx);
        return (addr[1:0] == 2'h0) && (addr[17:2] == idx);
    endfunction : reg_hit

    // one process per concern below, so each flag group stands alone
    // sticky status
    logic [9:0] reg_undervolt_flag_reg; // regulator 1..10 undervoltage
    logic [3:0] conv_undervolt_flag_reg; // converter 1..4 undervoltage
    logic [1:0] buck_overcurrent_flag_reg; // converter 1..2 high current
    logic [11:0] pin_event_flag_reg; // pin 1..12 events

    // software controls
    logic [31:0] group_mask_reg; // per-group masks, one means masked
    logic [23:0] pin_trigger_select_reg; // two bits per pin

    // bus response state
    logic [31:0] rdata_reg;
    logic ready_reg;
    logic slverr_reg;
    logic irq_reg;

    // decoded access
    logic fire; // access completes at this edge
    logic wr_fire;
    logic [31:0] wmask; // written ones honouring strobes
    logic [31:0] rd_word;
    logic mapped;
    logic [31:0] lanes; // strobe lanes as a bit mask

    // group pending summaries
    logic uv_pend;
    logic hc_pend;
    logic gp_pend;

    // both detectors use the same synchroniser, so latencies match
    // fault events always trigger on rising edges
    event_if #(.W(pmic_irq_pkg::N_FAULT)) fault_ev ();
    // pin events use their own trigger selection
    event_if #(.W(pmic_irq_pkg::N_PIN)) pin_ev ();

    logic [2*pmic_irq_pkg::N_FAULT-1:0] fault_modes;
    logic [pmic_irq_pkg::N_FAULT-1:0] fault_levels;

    // every fault source is a rising-edge source
    assign fault_modes = {pmic_irq_pkg::N_FAULT{pmic_irq_pkg::trig_rise}};
    // pack fault sources into one detector vector
    assign fault_levels = {buck_overcurrent_in, conv_undervolt_in, ldo_undervolt_in};

    // synchronise and edge-detect the fault conditions
    edge_trigger_detect #(
        .W(pmic_irq_pkg::N_FAULT)
    ) u_fault_detect (
        .clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in),
        .level_in(fault_levels),
        .mode_in(fault_modes),
        .ev(fault_ev.src)
    );

    // pin detector; mode comes straight from the selection register
    edge_trigger_detect #(
        .W(pmic_irq_pkg::N_PIN)
    ) u_pin_detect (
        .clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in),
        .level_in(pin_level_in),
        .mode_in(pin_trigger_select_reg),
        .ev(pin_ev.src)
    );

    // one wait state always; a request dropped early is simply lost
    // and leaves no half-done write behind
    // access is taken at the edge where the slave already shows ready
    assign fire = psel_in & penable_in & ready_reg;
    // writes only land on mapped words
    assign wr_fire = fire & pwrite_in & mapped;
    // strobe lanes decoded once for the flag and pin mode registers
    assign lanes = lane_mask(pstrb_in);
    // only ones in enabled lanes act
    assign wmask = pwdata_in & lanes;

    // address decode; unaligned or unknown words answer with an error
    always_comb
    begin
        mapped = reg_hit(paddr_in, pmic_irq_pkg::IDX_LDO_UV)
            | reg_hit(paddr_in, pmic_irq_pkg::IDX_CONV_FAULT)
            | reg_hit(paddr_in, pmic_irq_pkg::IDX_PIN_STATUS)
            | reg_hit(paddr_in, pmic_irq_pkg::IDX_GROUP_MASK)
            | reg_hit(paddr_in, pmic_irq_pkg::IDX_PIN_MODE)
            | reg_hit(paddr_in, pmic_irq_pkg::IDX_GROUP_PEND);
    end

    // set beats clear so an event on a clearing write is kept
    // regulator undervoltage flags; an event in the clearing cycle wins
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in)
        begin
            reg_undervolt_flag_reg <= '0;
        end
        else
        begin
            // clear by writing one, keep on zero, then set from events
            reg_undervolt_flag_reg <= (reg_undervolt_flag_reg
                & ~((wr_fire && reg_hit(paddr_in, pmic_irq_pkg::IDX_LDO_UV))
                    ? wmask[pmic_irq_pkg::N_LDO-1:0] : 10'h000))
                | fault_ev.pulse[pmic_irq_pkg::EV_LDO_LSB +: pmic_irq_pkg::N_LDO];
        end
    end

    // converter undervoltage flags
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in)
        begin
            conv_undervolt_flag_reg <= '0;
        end
        else
        begin
            // set wins over a simultaneous clear
            conv_undervolt_flag_reg <= (conv_undervolt_flag_reg
                & ~((wr_fire && reg_hit(paddr_in, pmic_irq_pkg::IDX_CONV_FAULT))
                    ? wmask[pmic_irq_pkg::CONV_UV_LSB +: pmic_irq_pkg::N_CONV] : 4'h0))
                | fault_ev.pulse[pmic_irq_pkg::EV_CONV_LSB +: pmic_irq_pkg::N_CONV];
        end
    end

    // converter high-current flags: index 0 is converter 1, index 1 converter 2
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in)
        begin
            buck_overcurrent_flag_reg <= '0;
        end
        else
        begin
            // bits 8 and 9 of the same register carry the clear
            buck_overcurrent_flag_reg <= (buck_overcurrent_flag_reg
                & ~((wr_fire && reg_hit(paddr_in, pmic_irq_pkg::IDX_CONV_FAULT))
                    ? wmask[pmic_irq_pkg::CONV_OC_LSB +: pmic_irq_pkg::N_OC] : 2'h0))
                | fault_ev.pulse[pmic_irq_pkg::EV_OC_LSB +: pmic_irq_pkg::N_OC];
        end
    end

    // pin flags share the clear path but trigger per pin
    // pin event flags; pin n sits at bit n-1
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in)
        begin
            pin_event_flag_reg <= '0;
        end
        else
        begin
            // in level mode a cleared flag comes back while the pin stays high
            pin_event_flag_reg <= (pin_event_flag_reg
                & ~((wr_fire && reg_hit(paddr_in, pmic_irq_pkg::IDX_PIN_STATUS))
                    ? wmask[pmic_irq_pkg::N_PIN-1:0] : 12'h000))
                | pin_ev.pulse;
        end
    end

    // masks reset high so nothing interrupts before software is ready
    // group masks; only the three group bits are writable
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in)
        begin
            group_mask_reg <= pmic_irq_pkg::MASK_RESET;
        end
        else if (wr_fire && reg_hit(paddr_in, pmic_irq_pkg::IDX_GROUP_MASK))
        begin
            // honour strobes, keep other bits zero
            group_mask_reg <= ((pwdata_in & lane_mask(pstrb_in))
                | (group_mask_reg & ~lane_mask(pstrb_in)))
                & pmic_irq_pkg::MASK_RESET;
        end
    end

    // no guard on mode writes: software clears the pin flags afterwards
    // pin trigger selection
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in)
        begin
            pin_trigger_select_reg <= pmic_irq_pkg::PIN_MODE_RESET;
        end
        else if (wr_fire && reg_hit(paddr_in, pmic_irq_pkg::IDX_PIN_MODE))
        begin
            // a mode change may itself produce one event on that pin
            pin_trigger_select_reg <= wmask[23:0]
                | (pin_trigger_select_reg & ~lanes[23:0]);
        end
    end

    // the undervoltage group covers regulators and converters alike
    // group summaries are plain ORs of their flags
    assign uv_pend = (|reg_undervolt_flag_reg) | (|conv_undervolt_flag_reg);
    assign hc_pend = |buck_overcurrent_flag_reg;
    assign gp_pend = |pin_event_flag_reg;

    // reads have no side effect; flags clear only on written ones
    // read mux; unlisted bits read zero
    always_comb
    begin
        rd_word = '0;
        if (reg_hit(paddr_in, pmic_irq_pkg::IDX_LDO_UV))
        begin
            rd_word[pmic_irq_pkg::N_LDO-1:0] = reg_undervolt_flag_reg;
        end
        else if (reg_hit(paddr_in, pmic_irq_pkg::IDX_CONV_FAULT))
        begin
            rd_word[pmic_irq_pkg::CONV_UV_LSB +: pmic_irq_pkg::N_CONV] =
                conv_undervolt_flag_reg;
            rd_word[pmic_irq_pkg::CONV_OC_LSB +: pmic_irq_pkg::N_OC] =
                buck_overcurrent_flag_reg;
        end
        else if (reg_hit(paddr_in, pmic_irq_pkg::IDX_PIN_STATUS))
        begin
            rd_word[pmic_irq_pkg::N_PIN-1:0] = pin_event_flag_reg;
        end
        else if (reg_hit(paddr_in, pmic_irq_pkg::IDX_GROUP_MASK))
        begin
            rd_word = group_mask_reg;
        end
        else if (reg_hit(paddr_in, pmic_irq_pkg::IDX_PIN_MODE))
        begin
            rd_word[23:0] = pin_trigger_select_reg;
        end
        else if (reg_hit(paddr_in, pmic_irq_pkg::IDX_GROUP_PEND))
        begin
            // live group pending, before masking
            rd_word[pmic_irq_pkg::PEND_UV_BIT] = uv_pend;
            rd_word[pmic_irq_pkg::PEND_HC_BIT] = hc_pend;
            rd_word[pmic_irq_pkg::PEND_GP_BIT] = gp_pend;
        end
        else
        begin
            rd_word = '0; // unmapped reads zero with an error
        end
    end

    // one wait state: ready rises the cycle after the access phase starts
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in)
        begin
            ready_reg <= 1'b0;
            slverr_reg <= 1'b0;
            rdata_reg <= '0;
        end
        else if (psel_in && penable_in && !ready_reg)
        begin
            // data captured here stays steady through the completing edge
            ready_reg <= 1'b1;
            slverr_reg <= ~mapped;
            rdata_reg <= pwrite_in ? 32'h0000_0000 : rd_word;
        end
        else
        begin
            // drop ready after the completing edge so the next access waits
            ready_reg <= 1'b0;
            slverr_reg <= 1'b0;
        end
    end

    // registered so the pin cannot glitch while flags and masks move
    // interrupt level, one cycle behind the flags; masked groups stay silent
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in)
        begin
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= (uv_pend & ~group_mask_reg[pmic_irq_pkg::MASK_UV_BIT])
                | (hc_pend & ~group_mask_reg[pmic_irq_pkg::MASK_HC_BIT])
                | (gp_pend & ~group_mask_reg[pmic_irq_pkg::MASK_GP_BIT]);
        end
    end

    // outputs straight from flops
    assign prdata_out = rdata_reg;
    assign pready_out = ready_reg;
    assign pslverr_out = slverr_reg;
    assign irq_out = irq_reg;

endmodule : pmic_irq_status
`default_nettype wire

// ---- test/pmic_irq_status_monitor.sv ----
// concurrent checks on the ports of the fault and pin interrupt status block
// assumes an apb master that holds each request until pready is seen high
`timescale 1ns/1ps
`default_nettype none
module pmic_irq_status_monitor (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    // apb side
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [17:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // system interrupt
    input wire logic irq_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);
    // completing edge of an access
    wire logic done = psel_in && penable_in && pready_out;
    wire logic rd_done = done && !pwrite_in;
    wire logic [17:0] a_ldo = {pmic_irq_pkg::IDX_LDO_UV, 2'b00};
    wire logic [17:0] a_conv = {pmic_irq_pkg::IDX_CONV_FAULT, 2'b00};
    wire logic [17:0] a_pin = {pmic_irq_pkg::IDX_PIN_STATUS, 2'b00};
    wire logic [17:0] a_mask = {pmic_irq_pkg::IDX_GROUP_MASK, 2'b00};
    wire logic [17:0] a_mode = {pmic_irq_pkg::IDX_PIN_MODE, 2'b00};
    wire logic [17:0] a_pend = {pmic_irq_pkg::IDX_GROUP_PEND, 2'b00};
    // every documented and own register
    wire logic mapped = paddr_in inside {a_ldo, a_conv, a_pin, a_mask, a_mode, a_pend};
    // shadow of the three group mask bits, all masked out of reset
    logic [2:0] mask_reg;
    // follows writes seen on the bus, lane by lane: strobe 0 updates bits 1:0, strobe 1 updates bit 2
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in)
            mask_reg <= 3'h7;
        else if (done && pwrite_in && paddr_in == a_mask)
        begin
            if (pstrb_in[0])
                mask_reg[1:0] <= pwdata_in[1:0];
            if (pstrb_in[1])
                mask_reg[2] <= pwdata_in[13];
        end
    end
    sequence s_setup;
        psel_in && !penable_in;
    endsequence
    sequence s_answer;
        !pready_out ##1 (pready_out && penable_in);
    endsequence
    a_one_wait: assert property (s_setup |=> s_answer)
        else $error("access did not finish after one wait state");
    a_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("ready held longer than one cycle");
    a_err_unmapped: assert property (done && !mapped |-> pslverr_out)
        else $error("unmapped access not refused");
    a_ok_mapped: assert property (done && mapped |-> !pslverr_out)
        else $error("mapped access refused");
    a_ldo_width: assert property (rd_done && paddr_in == a_ldo |-> prdata_out[31:10] == 22'h0)
        else $error("regulator status high bits set");
    a_conv_layout: assert property (rd_done && paddr_in == a_conv |->
        prdata_out[31:10] == 22'h0 && prdata_out[7:4] == 4'h0)
        else $error("converter status spare bits set");
    a_pin_width: assert property (rd_done && paddr_in == a_pin |-> prdata_out[31:12] == 20'h0)
        else $error("pin status high bits set");
    a_reset_quiet: assert property ($rose(rst_b_in) |-> !irq_out && !pready_out)
        else $error("outputs active straight after reset");
    a_masked_quiet: assert property ((mask_reg == 3'h7) [*3] |-> !irq_out)
        else $error("interrupt high with all groups masked");
    // the level is computed one edge earlier, from the mask seen then
    a_irq_cause: assert property ($rose(irq_out) |-> $past(mask_reg) != 3'h7)
        else $error("interrupt rose with all groups masked");
endmodule : pmic_irq_status_monitor
bind pmic_irq_status pmic_irq_status_monitor i_pmic_irq_status_monitor (.clk_sys_in, .rst_b_in,
    .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .prdata_out,
    .pready_out, .pslverr_out, .irq_out);
`default_nettype wire

// ---- test/test_regulator_fault_gpio_irq_status.sv ----
// self-checking bench for the fault and pin interrupt status block
// assumes the monitor file is compiled alongside and bound to the design
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin mismatches++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module test_regulator_fault_gpio_irq_status;
    localparam logic [15:0] ldo_i = pmic_irq_pkg::IDX_LDO_UV;
    localparam logic [15:0] conv_i = pmic_irq_pkg::IDX_CONV_FAULT;
    localparam logic [15:0] pin_i = pmic_irq_pkg::IDX_PIN_STATUS;
    localparam logic [15:0] mask_i = pmic_irq_pkg::IDX_GROUP_MASK;
    localparam logic [15:0] mode_i = pmic_irq_pkg::IDX_PIN_MODE;
    localparam logic [31:0] mrst = pmic_irq_pkg::MASK_RESET;
    // stimulus, all given at time zero
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [17:0] paddr = 18'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] strb = 4'hf;
    logic [9:0] ldo = 10'h0;
    logic [3:0] conv = 4'h0;
    logic [1:0] oc = 2'h0;
    logic [11:0] pin = 12'h0;
    // observed outputs
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    // expected {pslverr, prdata} per access, oldest first
    logic [32:0] exp_q[$];
    logic [32:0] note;
    logic [31:0] rnd = 32'h5f3f;
    logic [31:0] v, w, p;
    int gbit;
    int mismatches = 0;
    int checks_done = 0;
    always #25 clk_sys = ~clk_sys;
    // byte strobes full except in the strobe test
    pmic_irq_status i_pmic_irq_status (.clk_sys_in(clk_sys), .rst_b_in(rst_b),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .pstrb_in(strb), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .ldo_undervolt_in(ldo), .conv_undervolt_in(conv),
        .buck_overcurrent_in(oc), .pin_level_in(pin), .irq_out(irq));
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xorshift
    // one apb transfer; request held until ready is seen
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
        input logic [32:0] exp);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        exp_q.push_back(exp);
        @(posedge clk_sys);
        penable <= 1'b1;
        // ready is read at each rising edge, before the slave updates it
        do
            @(posedge clk_sys);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [15:0] idx, input logic [31:0] val);
        apb(1'b0, idx, 32'h0, {1'b0, val});
    endtask : rd
    // write answers carry zero data
    task automatic wr(input logic [15:0] idx, input logic [31:0] val);
        apb(1'b1, idx, val, 33'h0);
    endtask : wr
    // interrupt level sampled mid-cycle after n edges
    task automatic chk_irq(input int n, input logic e);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
        `CHECK(irq, e)
    endtask : chk_irq
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up
    // answer checker, oldest note against each ready cycle
    always @(negedge clk_sys)
    begin
        if (pready === 1'b1)
        begin
            note = (exp_q.size() != 0) ? exp_q.pop_front() : 33'h1ffffffff;
            `CHECK({pslverr, prdata}, note)
        end
    end
    // hang guard, far beyond the few hundred cycles of the tests
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        wrap_up();
    end
    initial
    begin
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        rd(ldo_i, 32'h0);
        rd(conv_i, 32'h0);
        rd(pin_i, 32'h0);
        rd(mask_i, mrst);
        rd(pmic_irq_pkg::IDX_GROUP_PEND, 32'h0);
        apb(1'b1, 16'h4016, 32'hffffffff, {1'b1, 32'h0});
        apb(1'b0, 16'h4016, 32'h0, {1'b1, 32'h0});
        chk_irq(0, 1'b0);
        $display("test reset done");
        // regulator flags: sticky, edge only, high bits ignored
        rnd = xorshift(rnd);
        v = (rnd & 32'h3ff) | 32'h201;
        ldo <= v[9:0];
        repeat (6) @(posedge clk_sys);
        rd(ldo_i, v);
        wr(ldo_i, 32'h0);
        rd(ldo_i, v);
        // ones in lanes without strobes clear nothing
        strb <= 4'h0;
        wr(ldo_i, 32'h3ff);
        strb <= 4'hf;
        rd(ldo_i, v);
        rnd = xorshift(rnd);
        w = rnd & v;
        wr(ldo_i, 32'hfffffc00 | w);
        rd(ldo_i, v & ~w);
        ldo <= 10'h0;
        wr(ldo_i, 32'h3ff);
        rd(ldo_i, 32'h0);
        $display("test regulator done");
        // converter undervoltage and both high-current flags
        for (int k = 0; k < 2; k++)
        begin
            rnd = xorshift(rnd);
            v = (32'h100 << k) | (rnd & 32'hf);
            conv <= v[3:0];
            oc <= v[9:8];
            repeat (6) @(posedge clk_sys);
            rd(conv_i, v);
            conv <= 4'h0;
            oc <= 2'h0;
            wr(conv_i, 32'h30f);
            rd(conv_i, 32'h0);
        end
        $display("test converter done");
        // every pin trigger mode on a random pin set
        for (int m = 0; m < 4; m++)
        begin
            rnd = xorshift(rnd);
            p = (rnd & 32'hfff) | 32'h801;
            wr(mode_i, {8'h0, {12{m[1:0]}}});
            repeat (6) @(posedge clk_sys);
            wr(pin_i, 32'hfff);
            pin <= p[11:0];
            repeat (6) @(posedge clk_sys);
            rd(pin_i, (m == 1) ? 32'h0 : p);
            wr(pin_i, 32'hfff);
            rd(pin_i, (m == 3) ? p : 32'h0);
            pin <= 12'h0;
            repeat (6) @(posedge clk_sys);
            rd(pin_i, (m == 0) ? 32'h0 : p);
        end
        wr(mode_i, 32'h0);
        repeat (6) @(posedge clk_sys);
        wr(pin_i, 32'hfff);
        $display("test pin modes done");
        // each group: masked, unmasked, pending, masked again, cleared
        for (int g = 0; g < 3; g++)
        begin
            gbit = (g == 2) ? 13 : g;
            ldo <= (g == 0) ? 10'h1 : 10'h0;
            oc <= (g == 1) ? 2'h1 : 2'h0;
            pin <= (g == 2) ? 12'h1 : 12'h0;
            chk_irq(6, 1'b0);
            wr(mask_i, mrst & ~(32'h1 << gbit));
            chk_irq(3, 1'b1);
            rd(pmic_irq_pkg::IDX_GROUP_PEND, 32'h1 << g);
            wr(mask_i, mrst);
            chk_irq(3, 1'b0);
            wr(mask_i, mrst & ~(32'h1 << gbit));
            ldo <= 10'h0;
            oc <= 2'h0;
            pin <= 12'h0;
            wr((g == 0) ? ldo_i : (g == 1) ? conv_i : pin_i, (g == 1) ? 32'h100 : 32'h1);
            chk_irq(3, 1'b0);
            wr(mask_i, mrst);
        end
        $display("test group masks done");
        wrap_up();
    end
endmodule : test_regulator_fault_gpio_irq_status
`default_nettype wire
